// >>> hw/dsg_ctrl.sv
// Deep-sleep unit clock gating register with AXI4-Lite access and interrupt.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dsg_ctrl
  import dsg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dsg_pkg::DSG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dsg_pkg::DSG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] run_unit_clock_gate_one,
  input wire logic [31:0] sleep_unit_clock_gate_one,
  input wire logic auto_sleep_gating_select,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic periph_req,
  input wire logic [dsg_pkg::DSG_UNIT_IDX_W-1:0] periph_unit,
  output logic periph_done,
  output logic periph_fault,
  output logic async_serial_zero_clock_gate,
  output logic sync_serial_zero_clock_gate,
  output logic gp_counter_zero_clock_gate,
  output logic gp_counter_one_clock_gate,
  output logic gp_counter_two_clock_gate,
  output logic comparator_zero_clock_gate,
  output logic comparator_one_clock_gate,
  output logic irq
);
  import dsg_pkg::*;

  typedef struct packed {
    logic aw_hold;
    logic [DSG_ADDR_W-1:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] gate;
    logic [DSG_EVT_W-1:0] status;
    logic [DSG_EVT_W-1:0] mask;
    logic irq;
    dsg_mode_t mode;
    logic [DSG_UNITS-1:0] unit_en;
  } dsg_top_state_t;

  dsg_top_state_t st_q;
  dsg_top_state_t nx;
  logic [DSG_UNITS-1:0] sel_en;
  logic fault_q;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  function automatic dsg_sel_t word_sel(input logic [DSG_ADDR_W-1:0] a);
    dsg_sel_t s;
    s = DSG_SEL_NONE;
    if (a[11:2] == DSG_OFF_DEEP_GATE[11:2])
    begin
      s = DSG_SEL_DEEP;
    end
    else if (a[11:2] == DSG_OFF_STATUS[11:2])
    begin
      s = DSG_SEL_STATUS;
    end
    else if (a[11:2] == DSG_OFF_MASK[11:2])
    begin
      s = DSG_SEL_MASK;
    end
    else if (a[11:2] == DSG_OFF_EFFECTIVE[11:2])
    begin
      s = DSG_SEL_EFF;
    end
    return s;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // ****************************************************************
  // Submodules.
  // ****************************************************************
  dsg_gate_select u_sel (
    .mode(st_q.mode),
    .auto_sel(auto_sleep_gating_select),
    .run_word(run_unit_clock_gate_one),
    .sleep_word(sleep_unit_clock_gate_one),
    .deep_word(st_q.gate),
    .unit_en(sel_en)
  );

  dsg_access_check u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .unit_en(st_q.unit_en),
    .periph_req(periph_req),
    .periph_unit(periph_unit),
    .periph_done(periph_done),
    .periph_fault(fault_q)
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    logic wr_fire;
    logic [31:0] bmask;
    logic [DSG_EVT_W-1:0] evt;
    logic [DSG_EVT_W-1:0] clr;
    nx = st_q;
    wr_fire = 1'b0;
    bmask = '0;
    evt = '0;
    clr = '0;
    if (s_axi_awvalid && st_q.awready)
    begin
      nx.aw_hold = 1'b1;
      nx.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      nx.w_hold = 1'b1;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end
    // Address and data may arrive in either order; the write acts once both are held.
    wr_fire = st_q.aw_hold && st_q.w_hold && !st_q.bvalid;
    if (wr_fire)
    begin
      nx.aw_hold = 1'b0;
      nx.w_hold = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = DSG_RESP_OKAY;
      bmask = strb_mask(st_q.wstrb);
      case (word_sel(st_q.awaddr))
        DSG_SEL_DEEP:
        begin
          // Only the seven enable bits take data; reserved bits stay zero.
          bmask = bmask & DSG_GATE_WR_MASK;
          nx.gate = (st_q.gate & ~bmask) | (st_q.wdata & bmask);
        end
        DSG_SEL_MASK:
        begin
          nx.mask = (st_q.mask & ~bmask[DSG_EVT_W-1:0])
            | (st_q.wdata[DSG_EVT_W-1:0] & bmask[DSG_EVT_W-1:0]);
        end
        DSG_SEL_STATUS, DSG_SEL_EFF:
        begin
          nx.bresp = DSG_RESP_OKAY;
        end
        default:
        begin
          nx.bresp = DSG_RESP_SLVERR;
        end
      endcase
    end
    else if (st_q.bvalid && s_axi_bready)
    begin
      nx.bvalid = 1'b0;
    end
    nx.awready = !nx.aw_hold && !nx.bvalid;
    nx.wready = !nx.w_hold && !nx.bvalid;

    if (s_axi_arvalid && st_q.arready)
    begin
      nx.rvalid = 1'b1;
      nx.rresp = DSG_RESP_OKAY;
      nx.rdata = '0;
      case (word_sel(s_axi_araddr))
        DSG_SEL_DEEP:
        begin
          nx.rdata = st_q.gate;
        end
        DSG_SEL_STATUS:
        begin
          nx.rdata = 32'(st_q.status);
          clr = '1;
        end
        DSG_SEL_MASK:
        begin
          nx.rdata = 32'(st_q.mask);
        end
        DSG_SEL_EFF:
        begin
          nx.rdata = 32'(st_q.unit_en);
        end
        default:
        begin
          nx.rresp = DSG_RESP_SLVERR;
        end
      endcase
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      nx.rvalid = 1'b0;
    end
    nx.arready = !nx.rvalid;

    if (deep_sleep_active)
    begin
      nx.mode = DSG_MODE_DEEP;
    end
    else if (sleep_active)
    begin
      nx.mode = DSG_MODE_SLEEP;
    end
    else
    begin
      nx.mode = DSG_MODE_RUN;
    end
    nx.unit_en = sel_en;

    evt[DSG_EVT_FAULT] = fault_q;
    evt[DSG_EVT_DEEP] = (nx.mode == DSG_MODE_DEEP) && (st_q.mode != DSG_MODE_DEEP)
      && auto_sleep_gating_select;
    // An event in the cycle of a clearing read survives the clear.
    nx.status = (st_q.status & ~clr) | evt;
    nx.irq = |(nx.status & nx.mask);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      st_q.gate <= DSG_GATE_RESET;
      st_q.status <= DSG_STATUS_RESET;
      st_q.mask <= DSG_MASK_RESET;
      st_q.mode <= DSG_MODE_RUN;
    end
    else
    begin
      st_q <= nx;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign periph_fault = fault_q;
  assign irq = st_q.irq;
  assign async_serial_zero_clock_gate = st_q.unit_en[0];
  assign sync_serial_zero_clock_gate = st_q.unit_en[1];
  assign gp_counter_zero_clock_gate = st_q.unit_en[2];
  assign gp_counter_one_clock_gate = st_q.unit_en[3];
  assign gp_counter_two_clock_gate = st_q.unit_en[4];
  assign comparator_zero_clock_gate = st_q.unit_en[5];
  assign comparator_one_clock_gate = st_q.unit_en[6];

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_reset_gate_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (st_q.gate == DSG_GATE_RESET) && !irq)
    else $error("Gating register not zero after reset.");

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.gate & ~DSG_GATE_WR_MASK) == 32'h0000_0000)
    else $error("Reserved gating bit became set.");

  a_write_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.aw_hold && st_q.w_hold && !st_q.bvalid && (st_q.wstrb == 4'hF)
    && (word_sel(st_q.awaddr) == DSG_SEL_DEEP)
    |=> (st_q.gate == ($past(st_q.wdata) & DSG_GATE_WR_MASK)) && s_axi_bvalid)
    else $error("Full write did not land in the gating register.");

  a_deep_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.mode == DSG_MODE_DEEP) && auto_sleep_gating_select
    |=> st_q.unit_en == dsg_pack_units($past(st_q.gate)))
    else $error("Deep-sleep enables do not follow the gating register.");

  a_run_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.mode == DSG_MODE_RUN)
    |=> st_q.unit_en == dsg_pack_units($past(run_unit_clock_gate_one)))
    else $error("Run enables do not follow the run gating word.");

  a_sleep_no_auto: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.mode != DSG_MODE_RUN) && !auto_sleep_gating_select
    |=> st_q.unit_en == dsg_pack_units($past(run_unit_clock_gate_one)))
    else $error("Sleep gating applied without auto gating.");

  a_sleep_auto: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.mode == DSG_MODE_SLEEP) && auto_sleep_gating_select
    |=> st_q.unit_en == dsg_pack_units($past(sleep_unit_clock_gate_one)))
    else $error("Sleep enables do not follow the sleep gating word.");

  a_write_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken.");

  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_q |=> st_q.status[DSG_EVT_FAULT] ##1 1'b1)
    else $error("Bus fault did not set its status bit.");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (irq == |(st_q.status & st_q.mask)))
    else $error("Interrupt level disagrees with status and mask.");
endmodule // dsg_ctrl

// >>> pkg/dsg_pkg.sv
// Constants and types shared by the deep-sleep unit clock gating block.
package dsg_pkg;
  localparam int DSG_ADDR_W = 12;
  localparam int DSG_UNITS = 7;
  localparam int DSG_UNIT_IDX_W = 3;
  localparam int DSG_EVT_W = 2;
  localparam int DSG_EVT_FAULT = 0;
  localparam int DSG_EVT_DEEP = 1;
  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [11:0] DSG_OFF_DEEP_GATE = 12'h124;
  localparam logic [11:0] DSG_OFF_STATUS = 12'h200;
  localparam logic [11:0] DSG_OFF_MASK = 12'h204;
  localparam logic [11:0] DSG_OFF_EFFECTIVE = 12'h208;
  // ****************************************************************
  // Reset values, writable bits and response codes.
  // ****************************************************************
  localparam logic [31:0] DSG_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] DSG_GATE_WR_MASK = 32'h0307_0011;
  localparam logic [1:0] DSG_STATUS_RESET = 2'h0;
  localparam logic [1:0] DSG_MASK_RESET = 2'h0;
  localparam logic [1:0] DSG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSG_RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Field positions, one per gated unit.
  // ****************************************************************
  localparam int DSG_BIT_ASYNC0 = 0;
  localparam int DSG_BIT_SYNC0 = 4;
  localparam int DSG_BIT_CNT0 = 16;
  localparam int DSG_BIT_CNT1 = 17;
  localparam int DSG_BIT_CNT2 = 18;
  localparam int DSG_BIT_CMP0 = 24;
  localparam int DSG_BIT_CMP1 = 25;
  localparam int DSG_UNIT_BIT [DSG_UNITS] = '{DSG_BIT_ASYNC0, DSG_BIT_SYNC0,
    DSG_BIT_CNT0, DSG_BIT_CNT1, DSG_BIT_CNT2, DSG_BIT_CMP0, DSG_BIT_CMP1};
  typedef enum logic [2:0] {
    DSG_MODE_RUN = 3'h1,
    DSG_MODE_SLEEP = 3'h2,
    DSG_MODE_DEEP = 3'h4
  } dsg_mode_t;
  typedef enum logic [4:0] {
    DSG_SEL_NONE = 5'h01,
    DSG_SEL_DEEP = 5'h02,
    DSG_SEL_STATUS = 5'h04,
    DSG_SEL_MASK = 5'h08,
    DSG_SEL_EFF = 5'h10
  } dsg_sel_t;
  function automatic logic [DSG_UNITS-1:0] dsg_pack_units(input logic [31:0] word);
    logic [DSG_UNITS-1:0] u;
    u = '0;
    for (int i = 0; i < DSG_UNITS; i++)
    begin
      u[i] = word[DSG_UNIT_BIT[i]];
    end
    return u;
  endfunction
endpackage

// >>> hw/dsg_gate_select.sv
// Picks the gating word for the current power mode and extracts unit enables.
`timescale 1ns/1ns
module dsg_gate_select
  import dsg_pkg::*;
(
  input wire dsg_pkg::dsg_mode_t mode,
  input wire logic auto_sel,
  input wire logic [31:0] run_word,
  input wire logic [31:0] sleep_word,
  input wire logic [31:0] deep_word,
  output logic [dsg_pkg::DSG_UNITS-1:0] unit_en
);
  import dsg_pkg::*;
  logic [31:0] word;
  function automatic logic [31:0] pick_word(input dsg_mode_t m, input logic a,
    input logic [31:0] r, input logic [31:0] s, input logic [31:0] d);
    logic [31:0] w;
    w = r;
    if (a && (m == DSG_MODE_DEEP))
    begin
      w = d;
    end
    else if (a && (m == DSG_MODE_SLEEP))
    begin
      w = s;
    end
    return w;
  endfunction
  assign word = pick_word(mode, auto_sel, run_word, sleep_word, deep_word);
  genvar g;
  generate
    for (g = 0; g < DSG_UNITS; g++)
    begin : g_unit
      assign unit_en[g] = word[DSG_UNIT_BIT[g]];
    end
  endgenerate
endmodule // dsg_gate_select

// >>> hw/dsg_access_check.sv
// Answers unit accesses: normal completion when clocked, bus fault when not.
`timescale 1ns/1ns
module dsg_access_check
  import dsg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dsg_pkg::DSG_UNITS-1:0] unit_en,
  input wire logic periph_req,
  input wire logic [dsg_pkg::DSG_UNIT_IDX_W-1:0] periph_unit,
  output logic periph_done,
  output logic periph_fault
);
  import dsg_pkg::*;
  typedef struct packed {
    logic done;
    logic fault;
  } dsg_chk_state_t;
  dsg_chk_state_t st_q;
  dsg_chk_state_t nx;
  logic gated;
  // Indices above the last unit are not gated here and always complete.
  assign gated = (int'(periph_unit) < DSG_UNITS) && !unit_en[periph_unit];
  always_comb
  begin
    nx.done = periph_req && !gated;
    nx.fault = periph_req && gated;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= nx;
    end
  end
  assign periph_done = st_q.done;
  assign periph_fault = st_q.fault;
  a_fault_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    periph_req && gated |=> periph_fault && !periph_done)
    else $error("Access to unclocked unit gave no bus fault.");
  a_done_clocked: assert property (@(posedge aclk) disable iff (!aresetn)
    periph_req && !gated |=> periph_done && !periph_fault)
    else $error("Access to clocked unit did not complete.");
  a_idle_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !periph_req |=> !periph_done && !periph_fault)
    else $error("Answer without an access.");
endmodule // dsg_access_check

// >>> verification/tb.sv
// Self-checking testbench for the deep-sleep unit clock gating block.
`timescale 1ns/1ns
module tb;
  import dsg_pkg::*;
  // ****************************************************************
  // Stimulus, outputs and scoreboard.
  // ****************************************************************
  localparam logic [31:0] RW_BITS = 32'h0307_0011;
  logic aclk, aresetn, awv, wv, bp, arv, rp, auto_sel, slp, deep, preq;
  logic [11:0] aw, ar;
  logic [31:0] wd, run_w, slp_w, dw, d;
  logic [3:0] ws, s;
  logic [2:0] punit;
  wire awr, wr_r, bv, arr, rv, pdone, pfault, irq;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [6:0] g;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  logic [1:0] pq[$];
  int n_errors, tests_run, seed, i, k, b;

  dsg_ctrl i_dsg_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bp), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rp),
    .run_unit_clock_gate_one(run_w), .sleep_unit_clock_gate_one(slp_w),
    .auto_sleep_gating_select(auto_sel), .sleep_active(slp), .deep_sleep_active(deep),
    .periph_req(preq), .periph_unit(punit), .periph_done(pdone), .periph_fault(pfault),
    .async_serial_zero_clock_gate(g[0]), .sync_serial_zero_clock_gate(g[1]),
    .gp_counter_zero_clock_gate(g[2]), .gp_counter_one_clock_gate(g[3]),
    .gp_counter_two_clock_gate(g[4]), .comparator_zero_clock_gate(g[5]),
    .comparator_one_clock_gate(g[6]), .irq(irq));

  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // Unit enables in unit index order, taken straight from the bit layout.
  function automatic logic [6:0] units(input logic [31:0] w);
    return {w[25], w[24], w[18], w[17], w[16], w[4], w[0]};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo;
    n_errors++;
    $display("Error at %0t: no answer within the wait limit", $time);
    results();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] x, input logic [3:0] m,
    input logic [1:0] e);
    int n;
    wq.push_back(e);
    @(posedge aclk);
    aw <= a;
    wd <= x;
    ws <= m;
    awv <= 1'h1;
    wv <= 1'h1;
    bp <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_r) wv <= 1'h0;
      n++;
    end
    while (!(bv && bp) && n < 50);
    bp <= 1'h0;
    if (n >= 50) tmo();
  endtask

  task automatic rdq(input logic [11:0] a, input logic [31:0] x, input logic [1:0] e);
    int n;
    rq.push_back({e, x});
    @(posedge aclk);
    ar <= a;
    arv <= 1'h1;
    rp <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'h0;
      n++;
    end
    while (!(rv && rp) && n < 50);
    rp <= 1'h0;
    if (n >= 50) tmo();
  endtask

  task automatic acc(input logic [2:0] u, input logic f);
    pq.push_back({!f, f});
    @(posedge aclk);
    preq <= 1'h1;
    punit <= u;
    @(posedge aclk);
    preq <= 1'h0;
  endtask

  task automatic mode(input logic sv, input logic dv, input logic av, input logic [31:0] w);
    @(posedge aclk);
    slp <= sv;
    deep <= dv;
    auto_sel <= av;
    repeat (3) @(posedge aclk);
    chk(g, units(w));
  endtask

  // Results are matched against the oldest note as soon as they show.
  always @(posedge aclk)
  begin
    if (aresetn && bv && bp) chk(br, wq.size() ? wq.pop_front() : 'x);
    if (aresetn && rv && rp) chk({rr, rd}, rq.size() ? rq.pop_front() : 'x);
    if (aresetn && (pdone || pfault)) chk({pdone, pfault}, pq.size() ? pq.pop_front() : 'x);
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    seed = 40223;
    {aresetn, awv, wv, bp, arv, rp, auto_sel, slp, deep, preq} = '0;
    aw = '0;
    ar = '0;
    wd = '0;
    ws = '0;
    punit = '0;
    run_w = '0;
    slp_w = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdq(DSG_OFF_DEEP_GATE, 32'h0, DSG_RESP_OKAY);
    rdq(DSG_OFF_STATUS, 32'h0, DSG_RESP_OKAY);
    rdq(DSG_OFF_MASK, 32'h0, DSG_RESP_OKAY);
    chk(g, 7'h00);
    for (i = 0; i < 32; i++)
    begin
      wr(DSG_OFF_DEEP_GATE, 32'h1 << i, 4'hF, DSG_RESP_OKAY);
      rdq(DSG_OFF_DEEP_GATE, (32'h1 << i) & RW_BITS, DSG_RESP_OKAY);
    end
    dw = '0;
    for (i = 0; i < 6; i++)
    begin
      d = $random(seed);
      s = 4'($random(seed));
      for (b = 0; b < 4; b++)
        if (s[b]) dw[8*b+:8] = d[8*b+:8];
      dw = dw & RW_BITS;
      wr(DSG_OFF_DEEP_GATE, d, s, DSG_RESP_OKAY);
      rdq(DSG_OFF_DEEP_GATE, dw, DSG_RESP_OKAY);
    end
    wr(12'h300, $random(seed), 4'hF, DSG_RESP_SLVERR);
    rdq(12'h300, 32'h0, DSG_RESP_SLVERR);
    rdq(DSG_OFF_DEEP_GATE, dw, DSG_RESP_OKAY);
    run_w <= $random(seed);
    slp_w <= $random(seed);
    @(posedge aclk);
    for (k = 0; k < 8; k++)
      mode(k[2], k[1], k[0], k[0] ? (k[1] ? dw : (k[2] ? slp_w : run_w)) : run_w);
    // Leave deep-sleep first so that the next step is a fresh entry with auto gating.
    mode(1'h0, 1'h0, 1'h1, run_w);
    mode(1'h0, 1'h1, 1'h1, dw);
    rdq(DSG_OFF_EFFECTIVE, {25'h0, units(dw)}, DSG_RESP_OKAY);
    wr(DSG_OFF_EFFECTIVE, 32'hFFFF_FFFF, 4'hF, DSG_RESP_OKAY);
    dw = 32'h0201_0010;
    wr(DSG_OFF_DEEP_GATE, dw, 4'hF, DSG_RESP_OKAY);
    d = {25'h0, units(dw)};
    repeat (2) @(posedge aclk);
    chk(g, units(dw));
    for (i = 0; i < 8; i++)
    begin
      pq.push_back(i == 7 ? 2'h2 : {d[i], !d[i]});
      @(posedge aclk);
      preq <= 1'h1;
      punit <= i[2:0];
    end
    @(posedge aclk);
    preq <= 1'h0;
    repeat (3) @(posedge aclk);
    rdq(DSG_OFF_STATUS, 32'h3, DSG_RESP_OKAY);
    rdq(DSG_OFF_STATUS, 32'h0, DSG_RESP_OKAY);
    wr(DSG_OFF_MASK, 32'h1, 4'hF, DSG_RESP_OKAY);
    rdq(DSG_OFF_MASK, 32'h1, DSG_RESP_OKAY);
    chk(irq, 1'h0);
    acc(3'h0, 1'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'h1);
    rdq(DSG_OFF_STATUS, 32'h1, DSG_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    wr(DSG_OFF_MASK, 32'h2, 4'hF, DSG_RESP_OKAY);
    acc(3'h5, 1'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'h0);
    wr(DSG_OFF_MASK, 32'h1, 4'hF, DSG_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h1);
    acc(3'h2, 1'h0);
    // The answer must be seen before reset drops, or its note is never checked.
    @(posedge aclk);
    // A second reset in mid-run must clear the register and fall back to run mode.
    slp <= 1'h0;
    deep <= 1'h0;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    chk(g, units(run_w));
    rdq(DSG_OFF_DEEP_GATE, 32'h0, DSG_RESP_OKAY);
    rdq(DSG_OFF_MASK, 32'h0, DSG_RESP_OKAY);
    repeat (2) @(posedge aclk);
    // Every noted answer must have been seen by now.
    chk(34'(wq.size() + rq.size() + pq.size()), 34'h0);
    results();
  end
endmodule // tb
